// ### verilog/fifo_wait_map.vh
// Register map, field positions and timing counts for the FIFO wait
// and error block. Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef FIFO_WAIT_MAP_VH
`define FIFO_WAIT_MAP_VH

// ----------------------------------------
// Register indices (byte address bits 4:2)
// ----------------------------------------
`define FW_REG_DATA 3'h0
`define FW_REG_CTRL 3'h1
`define FW_REG_STAT 3'h2
`define FW_REG_RPTR 3'h3
`define FW_REG_WPTR 3'h4

// ----------------------------------------
// Status flag and mask bit positions
// ----------------------------------------
`define FW_UF 0
`define FW_OF 1
`define FW_RXW 2
`define FW_TXW 3
`define FW_IP 4
`define FW_FAE 5
`define FW_NFLAG 6

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define FW_CTRL_FRAME 8
`define FW_CTRL_SZ_LO 12
`define FW_CTRL_SZ_HI 13
`define FW_SZ_QUARTER 2'h0
`define FW_SZ_HALF 2'h1
`define FW_STAT_LVL_LO 8

// ----------------------------------------
// Access sizes and hold counts
// ----------------------------------------
`define FW_BE_LONG 4'hf
`define FW_LONG_N 3'h4
`define FW_BYTE_N 3'h1
`define FW_DBG_HOLD 2'h3
`define FW_ALIGN_MASK 2'h0

`endif

// ### verilog/fifo_wait_error.v
// FIFO controller core with wait-state generation and error flags.
// Assumes the peripheral and the arbiter of the shared RAM run on CLOCK.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`include "fifo_wait_map.vh"
`default_nettype none

module fifo_wait_error #(
    parameter DEPTH = 64,
    parameter PW = 6
) (
    // Clock, reset and enable
    input wire CLOCK,
    input wire SYS_RST,
    input wire CLK_EN,
    // Avalon-MM slave
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [3:0] AVS_BYTEENABLE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // Peripheral write side
    input wire PERIPH_WR_REQ,
    input wire [2:0] PERIPH_WR_CNT,
    input wire [31:0] PERIPH_WR_DATA,
    output reg PERIPH_WR_ACK,
    // Peripheral read side
    input wire PERIPH_RD_REQ,
    input wire [2:0] PERIPH_RD_CNT,
    output reg [31:0] PERIPH_RD_DATA,
    output reg PERIPH_RD_ACK,
    // Alarms, shared RAM and frame state
    input wire ALARM_IN,
    input wire FRAME_READY_IN,
    input wire PRIO_HOLD,
    input wire FRAME_RETRY_HOLD,
    input wire FRAME_REJECTED,
    // Error output
    output reg ERROR_OUT
);

    localparam [PW:0] FULL_SZ = DEPTH;
    localparam [PW:0] HALF_SZ = DEPTH / 2;
    localparam [PW:0] QUAR_SZ = DEPTH / 4;

    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    reg [7:0] mem [0:DEPTH-1];
    reg [PW-1:0] rd_ptr_q;
    reg [PW-1:0] wr_ptr_q;
    reg [PW:0] level_q;
    reg [PW:0] level_d;
    reg [`FW_NFLAG-1:0] flags_q;
    reg [`FW_NFLAG-1:0] flags_d;
    reg [`FW_NFLAG-1:0] mask_q;
    reg frame_en_q;
    reg [1:0] size_sel_q;
    reg [1:0] hold_q;
    reg alarm_q;
    reg frdy_q;
    reg mis_done_q;
    reg [PW:0] fifo_size;
    reg [31:0] rdata;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [PW-1:0] wrap;
        input [PW-1:0] p;
        input [2:0] i;
        input [PW:0] sz;
        reg [PW:0] s;
        reg [PW:0] m;
        begin
            s = {1'b0, p} + {{(PW-2){1'b0}}, i};
            m = sz - {{PW{1'b0}}, 1'b1};
            wrap = s[PW-1:0] & m[PW-1:0];
        end
    endfunction

    function [PW:0] ext;
        input [2:0] n;
        begin
            ext = {{(PW-2){1'b0}}, n};
        end
    endfunction

    // Byte lanes gathered from the read pointer onward.
    function [31:0] gather;
        input [PW-1:0] p;
        input [PW:0] sz;
        input [7:0] b0;
        input [7:0] b1;
        input [7:0] b2;
        input [7:0] b3;
        begin
            gather = {b3, b2, b1, b0};
        end
    endfunction

    always @* begin
        case (size_sel_q)
            `FW_SZ_QUARTER: fifo_size = QUAR_SZ;
            `FW_SZ_HALF: fifo_size = HALF_SZ;
            default: fifo_size = FULL_SZ;
        endcase
    end

    wire [PW:0] free_w = fifo_size - level_q;
    wire [31:0] fifo_word = gather(rd_ptr_q, fifo_size,
        mem[wrap(rd_ptr_q, 3'h0, fifo_size)],
        mem[wrap(rd_ptr_q, 3'h1, fifo_size)],
        mem[wrap(rd_ptr_q, 3'h2, fifo_size)],
        mem[wrap(rd_ptr_q, 3'h3, fifo_size)]);

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire [2:0] reg_sel = AVS_ADDRESS[4:2];
    wire window = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
    wire data_sel = reg_sel == `FW_REG_DATA;
    wire bus_rd_fifo = AVS_READ & data_sel;
    wire bus_wr_fifo = AVS_WRITE & data_sel;
    wire is_long = AVS_BYTEENABLE == `FW_BE_LONG;
    wire [2:0] bus_n = is_long ? `FW_LONG_N : `FW_BYTE_N;
    wire hold_busy = hold_q != 2'h0;

    // ----------------------------------------
    // Wait causes
    // ----------------------------------------
    // The transfer is held in the very cycle either alarm falls.
    wire alarm_fall = (alarm_q & ~ALARM_IN) | (frdy_q & ~FRAME_READY_IN);
    // Common stalls: shared RAM owner, pointer resync, alarm fall.
    wire common_stall = PRIO_HOLD | hold_busy | alarm_fall;

    wire per_wr_block = PERIPH_WR_REQ & (free_w < ext(PERIPH_WR_CNT));
    wire per_rd_block = PERIPH_RD_REQ & (level_q < ext(PERIPH_RD_CNT));

    wire per_wr_go = PERIPH_WR_REQ & ~PERIPH_WR_ACK & ~common_stall & ~per_wr_block;
    wire per_rd_go = PERIPH_RD_REQ & ~PERIPH_RD_ACK & ~common_stall & ~per_rd_block;

    // Only longword reads pay the misalignment penalty, once.
    wire mis_stall = bus_rd_fifo & is_long & (rd_ptr_q[1:0] != `FW_ALIGN_MASK)
        & ~mis_done_q;

    // The peripheral wins when both want the same operation.
    wire contend = (bus_wr_fifo & per_wr_go) | (bus_rd_fifo & per_rd_go);

    wire bus_stall = data_sel & (common_stall | mis_stall | contend);
    wire bus_go = window & ~bus_stall;

    wire do_bw = bus_go & bus_wr_fifo;
    wire do_br = bus_go & bus_rd_fifo;
    wire sw_rptr = bus_go & AVS_WRITE & (reg_sel == `FW_REG_RPTR);
    wire sw_wptr = bus_go & AVS_WRITE & (reg_sel == `FW_REG_WPTR);
    wire sw_ctrl = bus_go & AVS_WRITE & (reg_sel == `FW_REG_CTRL);
    wire sw_stat = bus_go & AVS_WRITE & (reg_sel == `FW_REG_STAT);
    wire [PW-1:0] sw_ptr = AVS_WRITEDATA[PW-1:0];

    // ----------------------------------------
    // Data movement
    // ----------------------------------------
    wire wr_go = do_bw | per_wr_go;
    wire [2:0] wr_n = do_bw ? bus_n : PERIPH_WR_CNT;
    wire [31:0] wr_data = do_bw ? AVS_WRITEDATA : PERIPH_WR_DATA;
    wire rd_go = do_br | per_rd_go;
    wire [2:0] rd_n = do_br ? bus_n : PERIPH_RD_CNT;

    wire bus_over = do_bw & (free_w < ext(bus_n));
    wire bus_under = do_br & (level_q < ext(bus_n));

    // Pointer difference used when software has moved a pointer.
    wire [PW-1:0] ptr_diff = wrap(wr_ptr_q - rd_ptr_q, 3'h0, fifo_size);

    always @* begin
        level_d = level_q;
        if (hold_q == 2'h1) begin
            // A zero difference is full only if it was at least half full.
            if (ptr_diff != {PW{1'b0}}) begin
                level_d = {1'b0, ptr_diff};
            end else if (level_q >= (fifo_size >> 1)) begin
                level_d = fifo_size;
            end else begin
                level_d = {(PW+1){1'b0}};
            end
        end else begin
            if (wr_go) begin
                level_d = level_d + ext(wr_n);
            end
            if (rd_go) begin
                level_d = level_d - ext(rd_n);
            end
            // Past a wrap the level is unreliable; pin it to an end.
            if (bus_over) begin
                level_d = fifo_size;
            end
            if (bus_under) begin
                level_d = {(PW+1){1'b0}};
            end
        end
    end

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    reg [`FW_NFLAG-1:0] set_v;
    reg [`FW_NFLAG-1:0] clr_v;

    always @* begin
        set_v = {`FW_NFLAG{1'b0}};
        set_v[`FW_UF] = bus_under;
        set_v[`FW_OF] = bus_over;
        set_v[`FW_RXW] = per_wr_block & ~common_stall;
        set_v[`FW_TXW] = per_rd_block & ~common_stall;
        set_v[`FW_IP] = (sw_rptr | sw_wptr) & ({1'b0, sw_ptr} >= fifo_size);
        set_v[`FW_FAE] = frame_en_q & ((do_bw & FRAME_RETRY_HOLD)
            | (do_br & FRAME_REJECTED));
        clr_v = sw_stat ? AVS_WRITEDATA[`FW_NFLAG-1:0] : {`FW_NFLAG{1'b0}};
        // A new event in the clearing cycle survives the clear.
        flags_d = (flags_q & ~clr_v) | set_v;
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always @* begin
        rdata = 32'h0000_0000;
        case (reg_sel)
            `FW_REG_DATA: rdata = is_long ? fifo_word : {24'h00_0000, fifo_word[7:0]};
            `FW_REG_CTRL: begin
                rdata[`FW_NFLAG-1:0] = mask_q;
                rdata[`FW_CTRL_FRAME] = frame_en_q;
                rdata[`FW_CTRL_SZ_HI:`FW_CTRL_SZ_LO] = size_sel_q;
            end
            `FW_REG_STAT: begin
                rdata[`FW_NFLAG-1:0] = flags_q;
                rdata[`FW_STAT_LVL_LO+PW:`FW_STAT_LVL_LO] = level_q;
            end
            `FW_REG_RPTR: rdata[PW-1:0] = rd_ptr_q;
            `FW_REG_WPTR: rdata[PW-1:0] = wr_ptr_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // FIFO RAM
    // ----------------------------------------
    // The RAM has no reset; its contents are only meaningful via pointers.
    integer i;
    always @(posedge CLOCK) begin
        if (CLK_EN && wr_go && !SYS_RST) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (i < wr_n) begin
                    mem[wrap(wr_ptr_q, i[2:0], fifo_size)] <= wr_data[8*i +: 8];
                end
            end
        end
    end

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    always @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_ptr_q <= {PW{1'b0}};
            wr_ptr_q <= {PW{1'b0}};
            level_q <= {(PW+1){1'b0}};
            flags_q <= {`FW_NFLAG{1'b0}};
            mask_q <= {`FW_NFLAG{1'b0}};
            frame_en_q <= 1'b0;
            size_sel_q <= 2'h3;
            hold_q <= 2'h0;
            alarm_q <= 1'b0;
            frdy_q <= 1'b0;
            mis_done_q <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
            AVS_WAITREQUEST <= 1'b1;
            PERIPH_WR_ACK <= 1'b0;
            PERIPH_RD_ACK <= 1'b0;
            PERIPH_RD_DATA <= 32'h0000_0000;
            ERROR_OUT <= 1'b0;
        end else if (CLK_EN) begin
            alarm_q <= ALARM_IN;
            frdy_q <= FRAME_READY_IN;
            level_q <= level_d;
            flags_q <= flags_d;
            // Error tracks the unmasked flags every cycle.
            ERROR_OUT <= |(flags_d & ~mask_q);

            // Wait drops for exactly one cycle per accepted access.
            AVS_WAITREQUEST <= ~bus_go;
            if (bus_go && AVS_READ) begin
                AVS_READDATA <= rdata;
            end

            PERIPH_WR_ACK <= per_wr_go;
            PERIPH_RD_ACK <= per_rd_go;
            if (per_rd_go) begin
                PERIPH_RD_DATA <= fifo_word;
            end

            if (mis_stall) begin
                mis_done_q <= 1'b1;
            end else if (do_br) begin
                mis_done_q <= 1'b0;
            end

            // Pointers keep moving even past an overflow or underflow.
            if (sw_rptr) begin
                rd_ptr_q <= sw_ptr;
            end else if (rd_go) begin
                rd_ptr_q <= wrap(rd_ptr_q, rd_n, fifo_size);
            end
            if (sw_wptr) begin
                wr_ptr_q <= sw_ptr;
            end else if (wr_go) begin
                wr_ptr_q <= wrap(wr_ptr_q, wr_n, fifo_size);
            end

            // Status is rebuilt over the hold before accesses resume.
            if (sw_rptr || sw_wptr) begin
                hold_q <= `FW_DBG_HOLD;
            end else if (hold_busy) begin
                hold_q <= hold_q - 2'h1;
            end

            if (sw_ctrl) begin
                mask_q <= AVS_WRITEDATA[`FW_NFLAG-1:0];
                frame_en_q <= AVS_WRITEDATA[`FW_CTRL_FRAME];
                size_sel_q <= AVS_WRITEDATA[`FW_CTRL_SZ_HI:`FW_CTRL_SZ_LO];
            end
        end
    end

endmodule

`default_nettype wire

// ### sim/fifo_wait_error_sva.sv
// Port assertions for the FIFO wait and error block.
// Assumes one clock domain and binding onto fifo_wait_error.
`default_nettype none
module fifo_wait_error_sva (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Register bus
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    // Peripheral and side inputs
    input wire logic PERIPH_WR_REQ,
    input wire logic PERIPH_WR_ACK,
    input wire logic PERIPH_RD_REQ,
    input wire logic PERIPH_RD_ACK,
    input wire logic ALARM_IN,
    input wire logic PRIO_HOLD,
    input wire logic ERROR_OUT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    logic req_w;
    logic dat_w;
    assign req_w = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN;
    assign dat_w = req_w && AVS_ADDRESS[4:2] == 3'h0;
    AST_REG_NOSTALL: assert property (req_w && AVS_ADDRESS[4:2] != 3'h0 |=> !AVS_WAITREQUEST)
        else $error("register access stalled");
    AST_ANS_CAUSE: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
        else $error("answer without request");
    AST_ANS_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("answer longer than one cycle");
    AST_PRIO_BUS: assert property (dat_w && PRIO_HOLD |=> AVS_WAITREQUEST)
        else $error("bus not held by shared RAM owner");
    AST_PRIO_PER: assert property (PRIO_HOLD && CLK_EN |=> !PERIPH_WR_ACK && !PERIPH_RD_ACK)
        else $error("peripheral not held by shared RAM owner");
    AST_ALARM_FALL: assert property (dat_w && $fell(ALARM_IN) |=> AVS_WAITREQUEST)
        else $error("alarm fall did not stall");
    AST_WR_CAUSE: assert property (PERIPH_WR_ACK |-> $past(PERIPH_WR_REQ) && !$past(PERIPH_WR_ACK))
        else $error("bad write ack");
    AST_RD_CAUSE: assert property (PERIPH_RD_ACK |-> $past(PERIPH_RD_REQ) && !$past(PERIPH_RD_ACK))
        else $error("bad read ack");
    AST_PTR_HOLD: assert property (req_w && AVS_WRITE && (AVS_ADDRESS[4:2] == 3'h3 || AVS_ADDRESS[4:2] == 3'h4)
        |=> ##1 !PERIPH_WR_ACK && !PERIPH_RD_ACK) else $error("access during pointer resync");
    COV_WR: cover property (PERIPH_WR_ACK);
    COV_RD: cover property (PERIPH_RD_ACK);
    COV_ERR: cover property (ERROR_OUT);
endmodule
bind fifo_wait_error fifo_wait_error_sva u_sva (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PERIPH_WR_REQ(PERIPH_WR_REQ), .PERIPH_WR_ACK(PERIPH_WR_ACK), .PERIPH_RD_REQ(PERIPH_RD_REQ),
    .PERIPH_RD_ACK(PERIPH_RD_ACK), .ALARM_IN(ALARM_IN), .PRIO_HOLD(PRIO_HOLD), .ERROR_OUT(ERROR_OUT));
`default_nettype wire

// ### sim/periph_model.sv
// Behavioural peripheral on the FIFO's peripheral ports.
// Assumes the bench raises a go input per transfer.
`default_nettype none
module periph_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic wr_go,
    input wire logic rd_go,
    input wire logic [2:0] cnt,
    input wire logic [31:0] data,
    // Peripheral ports
    output logic wr_req,
    output logic [2:0] wr_cnt,
    output logic [31:0] wr_data,
    input wire logic wr_ack,
    output logic rd_req,
    output logic [2:0] rd_cnt,
    input wire logic rd_ack
);
    logic [2:0] cnt_q;
    assign wr_cnt = cnt_q;
    assign rd_cnt = cnt_q;
    // A request holds until its ack; released data is inverted so stale bytes never look valid.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_req <= 1'b0;
            rd_req <= 1'b0;
            cnt_q <= 3'h1;
            wr_data <= 32'h0;
        end else begin
            if (wr_req && wr_ack) begin
                wr_req <= 1'b0;
                wr_data <= ~wr_data;
            end else if (!wr_req && wr_go) begin
                wr_req <= 1'b1;
                wr_data <= data;
                cnt_q <= cnt;
            end
            if (rd_req && rd_ack)
                rd_req <= 1'b0;
            else if (!rd_req && rd_go) begin
                rd_req <= 1'b1;
                cnt_q <= cnt;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/fifo_wait_error_tb_top.sv
// Self-checking bench for the FIFO wait and error block.
// Assumes the peripheral model and bound checker are compiled first.
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module fifo_wait_error_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 0, SYS_RST = 1, AVS_READ = 0, AVS_WRITE = 0, ALARM_IN = 0, FRAME_READY_IN = 0;
    logic PRIO_HOLD = 0, FRAME_REJECTED = 0, noise = 0, wr_go = 0, rd_go = 0, retry = 0;
    logic [3:0] be = 4'hf;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic [5:0] m;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, PERIPH_WR_DATA, PERIPH_RD_DATA, wd = 32'h0, q, d, first;
    logic [2:0] PERIPH_WR_CNT, PERIPH_RD_CNT, cnt = 3'h4;
    logic AVS_WAITREQUEST, PERIPH_WR_REQ, PERIPH_WR_ACK, PERIPH_RD_REQ, PERIPH_RD_ACK, ERROR_OUT;
    int errors = 0, n_tests = 0, cyc = 0;
    fifo_wait_error #(.DEPTH(64), .PW(6)) dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(1'b1),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(be),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .PERIPH_WR_REQ(PERIPH_WR_REQ), .PERIPH_WR_CNT(PERIPH_WR_CNT), .PERIPH_WR_DATA(PERIPH_WR_DATA),
        .PERIPH_WR_ACK(PERIPH_WR_ACK), .PERIPH_RD_REQ(PERIPH_RD_REQ), .PERIPH_RD_CNT(PERIPH_RD_CNT),
        .PERIPH_RD_DATA(PERIPH_RD_DATA), .PERIPH_RD_ACK(PERIPH_RD_ACK), .ALARM_IN(ALARM_IN),
        .FRAME_READY_IN(FRAME_READY_IN), .PRIO_HOLD(PRIO_HOLD), .FRAME_RETRY_HOLD(retry),
        .FRAME_REJECTED(FRAME_REJECTED), .ERROR_OUT(ERROR_OUT));
    periph_model per (.clk(CLOCK), .rst(SYS_RST), .wr_go(wr_go), .rd_go(rd_go), .cnt(cnt), .data(wd),
        .wr_req(PERIPH_WR_REQ), .wr_cnt(PERIPH_WR_CNT), .wr_data(PERIPH_WR_DATA), .wr_ack(PERIPH_WR_ACK),
        .rd_req(PERIPH_RD_REQ), .rd_cnt(PERIPH_RD_CNT), .rd_ack(PERIPH_RD_ACK));
    // ----
    // Tasks
    // ----
    function automatic logic err_exp(input logic [5:0] f, input logic [5:0] k);
        return |(f & ~k);
    endfunction
    task automatic final_report();
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] v, output logic [31:0] r);
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= v;
        do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
        r = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic per_wr(input logic [31:0] v);
        wd <= v;
        wr_go <= 1'b1;
        do @(posedge CLOCK); while (PERIPH_WR_ACK !== 1'b1);
        wr_go <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rst();
        SYS_RST <= 1'b1;
        repeat (6) @(posedge CLOCK);
        SYS_RST <= 1'b0;
    endtask
    initial forever #2.5 CLOCK = ~CLOCK;
    // Stalling inputs toggle at random; they never touch the flags, only the timing.
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
        ALARM_IN <= noise && !SYS_RST && $urandom_range(1);
        FRAME_READY_IN <= noise && !SYS_RST && $urandom_range(1);
        PRIO_HOLD <= noise && !SYS_RST && $urandom_range(7) == 0;
    end
    initial begin
        void'($urandom(32'h2a0e33e5));
        noise = 1'b1;
        rst();
        `CHK("waitreq", 1'b1, AVS_WAITREQUEST)
        bus(5'h00, 1'b0, 32'h0, q);
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("uf", 6'h01, q[5:0])
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 6'h3e : $urandom;
            bus(5'h04, 1'b1, {18'h0, 2'h3, 6'h0, m}, q);
            repeat (2) @(posedge CLOCK);
            `CHK("err", err_exp(6'h01, m), ERROR_OUT)
        end
        rst();
        for (int i = 0; i < 17; i++)
            bus(5'h00, 1'b1, $urandom, q);
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("of", 6'h02, q[5:0])
        `CHK("err", 1'b1, ERROR_OUT)
        rst();
        cnt <= 3'h2;
        rd_go <= 1'b1;
        repeat (8) @(posedge CLOCK);
        `CHK("rd_ack", 1'b0, PERIPH_RD_ACK)
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("txw", 6'h08, q[5:0])
        d = $urandom;
        bus(5'h00, 1'b1, d, q);
        do @(posedge CLOCK); while (PERIPH_RD_ACK !== 1'b1);
        rd_go <= 1'b0;
        `CHK("rd_data", d[15:0], PERIPH_RD_DATA[15:0])
        rst();
        cnt <= 3'h4;
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            if (i == 0)
                first = d;
            per_wr(d);
        end
        wr_go <= 1'b1;
        repeat (8) @(posedge CLOCK);
        `CHK("wr_ack", 1'b0, PERIPH_WR_ACK)
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("rxw", 6'h04, q[5:0])
        bus(5'h00, 1'b0, 32'h0, q);
        `CHK("fifo", first, q)
        do @(posedge CLOCK); while (PERIPH_WR_ACK !== 1'b1);
        wr_go <= 1'b0;
        rst();
        bus(5'h04, 1'b1, 32'h0, q);
        bus(5'h0c, 1'b1, 32'h0f, q);
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("ip", 6'h00, q[5:0])
        bus(5'h0c, 1'b1, 32'h14, q);
        bus(5'h0c, 1'b0, 32'h0, q);
        `CHK("rptr", 6'h14, q[5:0])
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("ip", 6'h10, q[5:0])
        rst();
        d = $urandom;
        first = $urandom;
        bus(5'h00, 1'b1, d, q);
        bus(5'h00, 1'b1, first, q);
        be <= 4'h1;
        bus(5'h00, 1'b0, 32'h0, q);
        `CHK("byte", {24'h0, d[7:0]}, q)
        be <= 4'hf;
        bus(5'h00, 1'b0, 32'h0, q);
        `CHK("misaligned", {first[7:0], d[31:8]}, q)
        rst();
        bus(5'h04, 1'b1, 32'h3100, q);
        per_wr(32'h0);
        FRAME_REJECTED <= 1'b1;
        bus(5'h00, 1'b0, 32'h0, q);
        FRAME_REJECTED <= 1'b0;
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("fae", 6'h20, q[5:0])
        bus(5'h08, 1'b1, 32'h3f, q);
        retry <= 1'b1;
        bus(5'h00, 1'b1, $urandom, q);
        retry <= 1'b0;
        bus(5'h08, 1'b0, 32'h0, q);
        `CHK("fae_retry", 6'h20, q[5:0])
        final_report();
    end
endmodule
`default_nettype wire
